// file: rchl_pkg.sv
// Purpose: constants for the route capability and owner-host lock registers
// Assumes: big-endian bit numbering in the map, bit 0 is the msb (bit 31 here)
// Notes: offsets are byte addresses within configuration space
package rchl_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam logic [23:0] OFS_TABLE_EXTENT = 24'h000034;
    localparam logic [23:0] OFS_MCAST_INFO = 24'h000038;
    localparam logic [23:0] OFS_OWNER_LOCK = 24'h000068;
    localparam logic [15:0] TABLE_EXTENT_VAL = 16'h01FF;
    localparam logic [15:0] FULL_RANGE_MAX = 16'hFFFF;
    localparam logic [15:0] OWNER_ID_RST = 16'hFFFF;
    localparam logic ASSOC_STYLE_VAL = 1'h0;
    localparam logic ASSOC_BREADTH_VAL = 1'h0;
    localparam logic [13:0] IDS_PER_MASK_M1_VAL = 14'h0000;
    localparam logic [15:0] MASK_COUNT_VAL = 16'h0008;
    localparam int ASSOC_STYLE_POS = 31;
    localparam int ASSOC_BREADTH_POS = 30;
    localparam int IDS_PER_MASK_LSB = 16;
    localparam int FIELD16_LSB = 0;
endpackage : rchl_pkg

// file: rchl_regs.sv
// Purpose: route table capacity, multicast capability and owner-host lock registers
// Assumes: one maintenance access per strobe, synchronous to mclk
// Notes: read data is registered, one cycle after the read strobe
`timescale 1ns/100ps
module rchl_regs #(
    parameter int NUM_PORTS = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // maintenance register access
    input wire logic regRdEn,
    input wire logic regWrEn,
    input wire logic [rchl_pkg::ADDR_W-1:0] regAddr,
    input wire logic [rchl_pkg::DATA_W-1:0] regWrData,
    output logic [rchl_pkg::DATA_W-1:0] regRdData,
    output logic regRdValid,
    // route check per port
    input wire logic [NUM_PORTS-1:0] smallTableMode,
    input wire logic [NUM_PORTS*16-1:0] destId,
    output logic [NUM_PORTS-1:0] destIdValid,
    // lock state
    output logic [15:0] ownerHostId,
    output logic ownerLocked
);
    import rchl_pkg::*;

    // address decode, shared by read and write paths
    logic hitExtent;
    logic hitMcast;
    logic hitOwner;
    logic ownerWr;

    // owner-host field state
    logic [15:0] ownerId_r;
    logic [15:0] ownerId_nxt;
    logic locked_r;
    logic locked_nxt;
    logic [15:0] wrId;
    logic idMatch;
    logic fieldOpen;
    logic takeReq;

    // capability field values, all constants
    logic [15:0] tableExtent;
    logic associationStyle;
    logic associationBreadth;
    logic [13:0] idsPerMaskMinusOne;
    logic [15:0] maskCount;

    // read path
    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] rdData_nxt;
    logic [DATA_W-1:0] extentWord;
    logic [DATA_W-1:0] mcastWord;
    logic [DATA_W-1:0] ownerWord;
    logic rdValid_r;

    // route check
    logic [NUM_PORTS-1:0] destValid_r;

    assign hitExtent = (regAddr == OFS_TABLE_EXTENT);
    assign hitMcast = (regAddr == OFS_MCAST_INFO);
    assign hitOwner = (regAddr == OFS_OWNER_LOCK);
    // no requester identity is checked: any host reaches every register
    assign ownerWr = regWrEn && hitOwner;

    assign tableExtent = TABLE_EXTENT_VAL;
    assign associationStyle = ASSOC_STYLE_VAL;
    assign associationBreadth = ASSOC_BREADTH_VAL;
    assign idsPerMaskMinusOne = IDS_PER_MASK_M1_VAL;
    assign maskCount = MASK_COUNT_VAL;

    assign wrId = regWrData[FIELD16_LSB +: 16];
    assign idMatch = (wrId == ownerId_r);
    assign fieldOpen = (ownerId_r == OWNER_ID_RST);
    // a write of the reset pattern leaves the field open
    assign takeReq = fieldOpen && (wrId != OWNER_ID_RST);

    // the field only changes through the owner decode
    always_comb begin
        ownerId_nxt = ownerId_r;
        if (ownerWr) begin
            if (fieldOpen) begin
                ownerId_nxt = wrId;
            end else if (idMatch) begin
                ownerId_nxt = OWNER_ID_RST;
            end else begin
                // held by another host: drop the write
                ownerId_nxt = ownerId_r;
            end
        end
    end

    // the lock flag follows the same decisions as the field
    always_comb begin
        locked_nxt = locked_r;
        if (ownerWr) begin
            if (fieldOpen) begin
                locked_nxt = takeReq;
            end else if (idMatch) begin
                locked_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ownerId_r <= OWNER_ID_RST;
        end else begin
            ownerId_r <= ownerId_nxt;
        end
    end

    // kept as its own flop so the lock output needs no compare
    always_ff @(posedge mclk) begin
        if (srst) begin
            locked_r <= 1'b0;
        end else begin
            locked_r <= locked_nxt;
        end
    end

    // reserved bits are tied low in every word
    always_comb begin
        extentWord = '0;
        extentWord[FIELD16_LSB +: 16] = tableExtent;
    end

    always_comb begin
        mcastWord = '0;
        mcastWord[ASSOC_STYLE_POS] = associationStyle;
        mcastWord[ASSOC_BREADTH_POS] = associationBreadth;
        mcastWord[IDS_PER_MASK_LSB +: 14] = idsPerMaskMinusOne;
        mcastWord[FIELD16_LSB +: 16] = maskCount;
    end

    always_comb begin
        ownerWord = '0;
        ownerWord[FIELD16_LSB +: 16] = ownerId_r;
    end

    // unmapped offsets read as zero
    // a read in the same cycle as a write returns the old value
    always_comb begin
        rdData_nxt = '0;
        if (hitExtent) begin
            rdData_nxt = extentWord;
        end else if (hitMcast) begin
            rdData_nxt = mcastWord;
        end else if (hitOwner) begin
            rdData_nxt = ownerWord;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData_r <= '0;
        end else if (regRdEn) begin
            rdData_r <= rdData_nxt;
        end
    end

    // regRdEn delayed one cycle: as many cycles high as the read strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= regRdEn;
        end
    end

    // one comparator per port; small table mode narrows the accepted range
    // the table-size select itself lives outside this block
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            logic [15:0] portId;
            logic validNxt;
            assign portId = destId[gi*16 +: 16];
            always_comb begin
                if (smallTableMode[gi]) begin
                    validNxt = (portId <= TABLE_EXTENT_VAL);
                end else begin
                    validNxt = (portId <= FULL_RANGE_MAX);
                end
            end
            always_ff @(posedge mclk) begin
                if (srst) begin
                    destValid_r[gi] <= 1'b0;
                end else begin
                    destValid_r[gi] <= validNxt;
                end
            end
        end
    endgenerate

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;
    assign destIdValid = destValid_r;
    assign ownerHostId = ownerId_r;
    assign ownerLocked = locked_r;
endmodule : rchl_regs

// file: rchl_regs_checker.sv
// Purpose: port checks for rchl_regs
// Assumes: strobes sampled on rising mclk
// Notes: route check watches port 0 only
`timescale 1ns/100ps
module rchl_chk #(parameter int NUM_PORTS = 16) (input logic mclk, srst, regRdEn, regWrEn, regRdValid, ownerLocked,
    input logic [23:0] regAddr, input logic [31:0] regWrData, regRdData, input logic [15:0] ownerHostId,
    input logic [NUM_PORTS-1:0] smallTableMode, destIdValid, input logic [NUM_PORTS*16-1:0] destId);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    wire lockWr = regWrEn && regAddr == 24'h000068;
    wire [15:0] wrId = regWrData[15:0];
    a_rd_valid: assert property (regRdValid == $past(regRdEn)) else $error("read valid off");
    a_extent_ro: assert property (regRdEn && regAddr == 24'h000034 |=> regRdData == 32'h000001FF) else $error("extent");
    a_mcast_caps: assert property (regRdEn && regAddr == 24'h000038 |=> regRdData == 32'h00000008) else $error("caps");
    a_owner_rd: assert property (regRdEn && regAddr == 24'h000068 |=> regRdData == {16'h0000, $past(ownerHostId)}) else $error("owner rd");
    a_lock_take: assert property (lockWr && !ownerLocked && wrId != 16'hFFFF |=> ownerLocked && ownerHostId == $past(wrId)) else $error("take");
    a_lock_keep: assert property (lockWr && ownerLocked && wrId != ownerHostId |=> $stable(ownerHostId)) else $error("keep");
    a_lock_free: assert property (lockWr && ownerLocked && wrId == ownerHostId |=> !ownerLocked && ownerHostId == 16'hFFFF) else $error("free");
    a_ffff_open: assert property (lockWr && !ownerLocked && wrId == 16'hFFFF |=> !ownerLocked) else $error("ffff");
    a_route_ok: assert property (1'b1 |=> destIdValid[0] == (!$past(smallTableMode[0]) || $past(destId[15:0]) <= 16'h01FF)) else $error("route");
endmodule : rchl_chk

// file: rchl_host.sv
// Purpose: host issuing maintenance accesses
// Assumes: drives on falling mclk
// Notes: released lines show inverted data
`timescale 1ns/100ps
module rchl_host (input logic mclk, output logic rdEn = 0, wrEn = 0, output logic [23:0] addr = 0, output logic [31:0] wd = 0);
    task automatic acc(input logic r, w, input logic [23:0] a, input logic [31:0] d);
        @(negedge mclk);
        {rdEn, wrEn, addr, wd} = {r, w, a, d};
        @(negedge mclk);
        {rdEn, wrEn, addr, wd} = {2'b00, ~a, ~d};
    endtask : acc
endmodule : rchl_host

// file: test_route_capability_host_lock_regs.sv
// Purpose: self-checking bench for rchl_regs
// Assumes: host model drives access strobes
// Notes: only port 0 route inputs vary
`timescale 1ns/100ps
module test_route_capability_host_lock_regs;
    logic mclk = 0, srst = 1, rdEn, wrEn, rdValid, locked;
    logic [23:0] a;
    logic [31:0] wd, rd;
    logic [15:0] stm = 16'hFFFF, dv, oid;
    logic [255:0] did = '0;
    int fails = 0, samples_checked = 0;
    rchl_host host (.mclk(mclk), .rdEn(rdEn), .wrEn(wrEn), .addr(a), .wd(wd));
    rchl_regs dut (.mclk(mclk), .srst(srst), .regRdEn(rdEn), .regWrEn(wrEn), .regAddr(a), .regWrData(wd),
        .regRdData(rd), .regRdValid(rdValid), .smallTableMode(stm), .destId(did), .destIdValid(dv),
        .ownerHostId(oid), .ownerLocked(locked));
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [23:0] ad, input logic [31:0] exp);
        host.acc(1'b1, 1'b0, ad, 32'h00000000);
        chk(rd, exp);
        chk({31'h0, rdValid}, 32'h00000001);
    endtask : rdc
    task automatic t_lock;
        rdc(24'h000068, 32'h0000FFFF);
        host.acc(1'b0, 1'b1, 24'h000068, 32'h0000FFFF);
        rdc(24'h000068, 32'h0000FFFF);
        chk({31'h0, locked}, 32'h00000000);
        host.acc(1'b0, 1'b1, 24'h000068, 32'hABCD0005);
        rdc(24'h000068, 32'h00000005);
        chk({31'h0, locked}, 32'h00000001);
        chk({16'h0, oid}, 32'h00000005);
        host.acc(1'b0, 1'b1, 24'h000068, 32'h00000007);
        rdc(24'h000068, 32'h00000005);
        host.acc(1'b0, 1'b1, 24'h000034, 32'hFFFFFFFF);
        rdc(24'h000034, 32'h000001FF);
        host.acc(1'b0, 1'b1, 24'h000038, 32'hFFFFFFFF);
        rdc(24'h000038, 32'h00000008);
        rdc(24'h000040, 32'h00000000);
        host.acc(1'b0, 1'b1, 24'h000068, 32'h00000005);
        rdc(24'h000068, 32'h0000FFFF);
        chk({31'h0, locked}, 32'h00000000);
        chk({16'h0, oid}, 32'h0000FFFF);
    endtask : t_lock
    task automatic t_route;
        logic [15:0] ids [4] = '{16'h0000, 16'h01FF, 16'h0200, 16'hFFFF};
        for (int m = 0; m < 2; m++) foreach (ids[i]) begin
            @(negedge mclk);
            stm[0] = m[0];
            did[15:0] = ids[i];
            @(negedge mclk);
            chk({31'h0, dv[0]}, {31'h0, m == 0 || ids[i] <= 16'h01FF});
        end
    endtask : t_route
    task automatic close_out;
        if (fails == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial forever #5 mclk = ~mclk;
    initial begin
        #100000;
        fails++;
        close_out();
    end
    initial begin
        repeat (3) @(negedge mclk);
        srst = 0;
        t_lock();
        t_route();
        close_out();
    end
endmodule : test_route_capability_host_lock_regs
bind rchl_regs rchl_chk #(.NUM_PORTS(NUM_PORTS)) chk (.*);
